/* hdl/ibss_pkg.sv */
// shared constants and types for the instrument bus status and service request block
package ibss_pkg;

	localparam int ADDR_W = 5;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_NS = 500;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;

	// bus command codes, attention asserted, parity bit dropped
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [1:0] GROUP_LISTEN = 2'h1;
	localparam logic [1:0] GROUP_TALK = 2'h2;

	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_LF = 8'h0A;

	// status summary byte field positions
	localparam int STB_FRESH = 0;
	localparam int STB_RANGE = 2;
	localparam int STB_ALARM = 3;
	localparam int STB_ERROR = 4;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;
	localparam int STB_LOG = 7;

	localparam logic [7:0] STB_RESET = 8'h00;
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

	typedef enum logic [1:0] {
		TERM_CRLF,
		TERM_LFCR,
		TERM_LF,
		TERM_EOI
	} ibss_term_t;

endpackage : ibss_pkg

/* hdl/ibss_hs_if.sv */
// handshake carrier between the bus controller logic and the two handshake engines
`timescale 1ns/1ps
interface ibss_hs_if;
	logic abort;
	logic acc_en;
	logic rx_stb;
	logic [7:0] rx_byte;
	logic rx_eoi;
	logic rx_atn;
	logic src_en;
	logic tx_req;
	logic [7:0] tx_byte;
	logic tx_eoi;
	logic tx_done;

	modport ctl (output abort, acc_en, src_en, tx_req, tx_byte, tx_eoi,
		input rx_stb, rx_byte, rx_eoi, rx_atn, tx_done);
	modport acc (input abort, acc_en, output rx_stb, rx_byte, rx_eoi, rx_atn);
	modport src (input abort, src_en, tx_req, tx_byte, tx_eoi, output tx_done);
endinterface : ibss_hs_if

/* hdl/ibss_acceptor.sv */
// acceptor handshake engine: takes one byte per data-valid cycle of the bus
`timescale 1ns/1ps
module ibss_acceptor (
	input wire logic clk,
	input wire logic reset,
	ibss_hs_if.acc hs,
	input wire logic dav_n_in,
	input wire logic atn_n_in,
	input wire logic eoi_n_in,
	input wire logic [7:0] dio_n_in,
	output logic nrfd_n_oe,
	output logic ndac_n_oe
);
	import ibss_pkg::*;

	typedef enum logic [1:0] {AH_IDLE, AH_WAIT, AH_TAKEN} ibss_ah_t;
	ibss_ah_t st_q, st_d;
	logic stb_q, stb_d;
	logic [7:0] byte_q, byte_d;
	logic eoi_q, eoi_d, atn_q, atn_d, nrfd_d, ndac_d;

	assign hs.rx_stb = stb_q;
	assign hs.rx_byte = byte_q;
	assign hs.rx_eoi = eoi_q;
	assign hs.rx_atn = atn_q;

	always_comb begin
		st_d = st_q;
		stb_d = 1'b0;
		byte_d = byte_q;
		eoi_d = eoi_q;
		atn_d = atn_q;
		case (st_q)
			AH_IDLE: begin
				if (hs.acc_en) begin
					st_d = AH_WAIT;
				end
			end
			AH_WAIT: begin
				if (!dav_n_in) begin
					byte_d = ~dio_n_in;
					eoi_d = ~eoi_n_in;
					atn_d = ~atn_n_in;
					stb_d = 1'b1;
					st_d = AH_TAKEN;
				end
			end
			AH_TAKEN: begin
				// hold accepted until the source drops data valid
				if (dav_n_in) begin
					st_d = AH_WAIT;
				end
			end
			default: st_d = AH_IDLE;
		endcase
		if (hs.abort || !hs.acc_en) begin
			st_d = AH_IDLE;
			stb_d = 1'b0;
		end
		nrfd_d = (st_d == AH_TAKEN);
		ndac_d = (st_d == AH_WAIT);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= AH_IDLE;
			stb_q <= 1'b0;
			byte_q <= 8'h00;
			eoi_q <= 1'b0;
			atn_q <= 1'b0;
			nrfd_n_oe <= 1'b0;
			ndac_n_oe <= 1'b0;
		end else begin
			st_q <= st_d;
			stb_q <= stb_d;
			byte_q <= byte_d;
			eoi_q <= eoi_d;
			atn_q <= atn_d;
			nrfd_n_oe <= nrfd_d;
			ndac_n_oe <= ndac_d;
		end
	end
endmodule : ibss_acceptor

/* hdl/ibss_source.sv */
// source handshake engine: places one byte on the bus and waits for acceptance
`timescale 1ns/1ps
module ibss_source (
	input wire logic clk,
	input wire logic reset,
	ibss_hs_if.src hs,
	input wire logic nrfd_n_in,
	input wire logic ndac_n_in,
	output logic [7:0] dio_n_oe,
	output logic dav_n_oe,
	output logic eoi_n_oe
);
	import ibss_pkg::*;

	typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_VALID} ibss_sh_t;
	ibss_sh_t st_q, st_d;
	logic [7:0] byte_q, byte_d;
	logic eoi_q, eoi_d, done_q, done_d, drive;
	logic [SETTLE_W-1:0] cnt_q, cnt_d;

	assign hs.tx_done = done_q;

	always_comb begin
		st_d = st_q;
		byte_d = byte_q;
		eoi_d = eoi_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		case (st_q)
			SH_IDLE: begin
				if (hs.tx_req) begin
					byte_d = hs.tx_byte;
					eoi_d = hs.tx_eoi;
					cnt_d = SETTLE_W'(SETTLE_CYC);
					st_d = SH_SETTLE;
				end
			end
			SH_SETTLE: begin
				// data must settle before valid, and every listener must be ready
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (nrfd_n_in) begin
					st_d = SH_VALID;
				end
			end
			SH_VALID: begin
				if (ndac_n_in) begin
					done_d = 1'b1;
					st_d = SH_IDLE;
				end
			end
			default: st_d = SH_IDLE;
		endcase
		if (hs.abort || !hs.src_en) begin
			st_d = SH_IDLE;
			done_d = 1'b0;
		end
		drive = (st_d != SH_IDLE);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= SH_IDLE;
			byte_q <= 8'h00;
			eoi_q <= 1'b0;
			cnt_q <= '0;
			done_q <= 1'b0;
			dio_n_oe <= 8'h00;
			dav_n_oe <= 1'b0;
			eoi_n_oe <= 1'b0;
		end else begin
			st_q <= st_d;
			byte_q <= byte_d;
			eoi_q <= eoi_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			dio_n_oe <= drive ? byte_d : 8'h00;
			dav_n_oe <= (st_d == SH_VALID);
			eoi_n_oe <= drive & eoi_d;
		end
	end
endmodule : ibss_source

/* hdl/ibss_device.sv */
// instrument bus port: addressing, bus commands, status byte and service request
// Summary of operation
// - talker and listener only, never controller
// - full handshakes, request, remote, clear; nothing more
// - listen drops talk, talk drops listen
// - bus address and four terminator choices
// - new address and terminator need a reset
// - remote enable enters remote, go-local leaves
// - interface clear aborts bus activity
// - local lockout disables front panel
// - device clear, selective only when listener
// - addressed commands ignored unless listen addressed
// - serial poll returns status byte until disabled
// - enabled set status bit pulls request low
// - serial poll clears latched status bits
// - request only when mask bit six set
// - status query reads without clearing
// - status bits stay latched until serial poll
// - enable mask written by enable command
// - bit seven marks data log done
// - bit five summarises standard event status
// - bit four error, bit three alarm
// - bit two any input out of range
// - bit zero fresh reading, bit one zero
`timescale 1ns/1ps
module ibss_device #(
	parameter int NUM_INPUTS = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] dio_n_in,
	output logic [7:0] dio_n_out,
	output logic [7:0] dio_n_oe,
	input wire logic dav_n_in,
	output logic dav_n_out,
	output logic dav_n_oe,
	input wire logic nrfd_n_in,
	output logic nrfd_n_out,
	output logic nrfd_n_oe,
	input wire logic ndac_n_in,
	output logic ndac_n_out,
	output logic ndac_n_oe,
	input wire logic eoi_n_in,
	output logic eoi_n_out,
	output logic eoi_n_oe,
	output logic srq_n_out,
	output logic srq_n_oe,
	input wire logic atn_n_in,
	input wire logic ren_n_in,
	input wire logic ifc_n_in,
	input wire logic [ibss_pkg::ADDR_W-1:0] addr_strap,
	input wire ibss_pkg::ibss_term_t term_strap,
	input wire logic talk_only_strap,
	input wire logic log_complete_flag,
	input wire logic esr_summary,
	input wire logic instrument_error,
	input wire logic alarm_active,
	input wire logic [NUM_INPUTS-1:0] sensor_above_range,
	input wire logic [NUM_INPUTS-1:0] temperature_above_range,
	input wire logic [NUM_INPUTS-1:0] sensor_below_range,
	input wire logic [NUM_INPUTS-1:0] temperature_below_range,
	input wire logic fresh_reading_flag,
	input wire logic sre_wr,
	input wire logic [7:0] sre_wdata,
	input wire logic stb_query,
	output logic [7:0] stb_rdata,
	output logic [7:0] sre_rdata,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic remote_mode,
	output logic local_lockout,
	output logic device_clear,
	output logic listen_active,
	output logic talk_active,
	output logic srq_active
);
	import ibss_pkg::*;

	// no controller lines are ever driven
	// one source and one acceptor engine, no trigger or parallel poll
	ibss_hs_if hs();

	ibss_acceptor u_acc (
		.clk(clk),
		.reset(reset),
		.hs(hs),
		.dav_n_in(dav_n_in),
		.atn_n_in(atn_n_in),
		.eoi_n_in(eoi_n_in),
		.dio_n_in(dio_n_in),
		.nrfd_n_oe(nrfd_n_oe),
		.ndac_n_oe(ndac_n_oe)
	);

	ibss_source u_src (
		.clk(clk),
		.reset(reset),
		.hs(hs),
		.nrfd_n_in(nrfd_n_in),
		.ndac_n_in(ndac_n_in),
		.dio_n_oe(dio_n_oe),
		.dav_n_oe(dav_n_oe),
		.eoi_n_oe(eoi_n_oe)
	);

	// open-collector lines only ever pull low
	logic pin_low_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_low_q <= 1'b0;
		end else begin
			pin_low_q <= 1'b0;
		end
	end
	assign dio_n_out = {8{pin_low_q}};
	assign dav_n_out = pin_low_q;
	assign nrfd_n_out = pin_low_q;
	assign ndac_n_out = pin_low_q;
	assign eoi_n_out = pin_low_q;
	assign srq_n_out = pin_low_q;

	logic atn_on, ren_on, ifc_on;
	assign atn_on = ~atn_n_in;
	assign ren_on = ~ren_n_in;
	assign ifc_on = ~ifc_n_in;

	// straps caught once after reset release
	logic boot_q, boot_d, talk_only_q, talk_only_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	ibss_term_t term_q, term_d;

	always_comb begin
		boot_d = 1'b1;
		// settings frozen after the first cycle
		addr_d = boot_q ? addr_q : addr_strap;
		term_d = boot_q ? term_q : term_strap;
		talk_only_d = boot_q ? talk_only_q : talk_only_strap;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			boot_q <= 1'b0;
			addr_q <= ADDR_RESET;
			term_q <= TERM_CRLF;
			talk_only_q <= 1'b0;
		end else begin
			boot_q <= boot_d;
			addr_q <= addr_d;
			term_q <= term_d;
			talk_only_q <= talk_only_d;
		end
	end

	// addressing, remote state and received data
	logic listen_q, listen_d, talk_q, talk_d, spe_q, spe_d;
	logic remote_q, remote_d, lockout_q, lockout_d, ren_seen_q;
	logic devclr_q, devclr_d, rx_valid_q, rx_valid_d, rx_end_q, rx_end_d;
	logic [7:0] rx_data_q, rx_data_d;
	logic [6:0] cmd;
	logic cmd_stb, data_stb;

	assign cmd = hs.rx_byte[6:0];
	assign cmd_stb = hs.rx_stb & hs.rx_atn;
	assign data_stb = hs.rx_stb & ~hs.rx_atn & listen_q;

	always_comb begin
		listen_d = listen_q;
		talk_d = talk_q;
		spe_d = spe_q;
		remote_d = remote_q;
		lockout_d = lockout_q;
		devclr_d = 1'b0;
		rx_valid_d = 1'b0;
		rx_data_d = rx_data_q;
		rx_end_d = rx_end_q;
		// remote on the rising edge of remote enable
		if (ren_on && !ren_seen_q) begin
			remote_d = 1'b1;
		end
		if (cmd_stb) begin
			if (cmd == {GROUP_LISTEN, addr_q}) begin
				listen_d = 1'b1;
				talk_d = 1'b0;
			end else if (cmd == CMD_UNL) begin
				listen_d = 1'b0;
			end else if (cmd[6:5] == GROUP_TALK) begin
				talk_d = (cmd[4:0] == addr_q);
				if (cmd[4:0] == addr_q) begin
					listen_d = 1'b0;
				end
			end else if (cmd == CMD_LLO) begin
				lockout_d = 1'b1;
			end else if (cmd == CMD_DCL || (cmd == CMD_SDC && listen_q)) begin
				// clear; selective form needs listen address
				devclr_d = 1'b1;
			end else if (cmd == CMD_GTL && listen_q) begin
				remote_d = 1'b0;
			end else if (cmd == CMD_SPE) begin
				spe_d = 1'b1;
			end else if (cmd == CMD_SPD) begin
				spe_d = 1'b0;
			end
		end
		if (!ren_on) begin
			remote_d = 1'b0;
			lockout_d = 1'b0;
		end
		if (ifc_on) begin
			listen_d = 1'b0;
			talk_d = 1'b0;
			spe_d = 1'b0;
		end
		// talk-only mode holds the talker role
		if (talk_only_q) begin
			talk_d = 1'b1;
			listen_d = 1'b0;
		end
		if (data_stb) begin
			rx_valid_d = 1'b1;
			rx_data_d = hs.rx_byte;
			rx_end_d = hs.rx_eoi | (hs.rx_byte == CHAR_LF);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			listen_q <= 1'b0;
			talk_q <= 1'b0;
			spe_q <= 1'b0;
			remote_q <= 1'b0;
			lockout_q <= 1'b0;
			ren_seen_q <= 1'b0;
			devclr_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_end_q <= 1'b0;
		end else begin
			listen_q <= listen_d;
			talk_q <= talk_d;
			spe_q <= spe_d;
			remote_q <= remote_d;
			lockout_q <= lockout_d;
			ren_seen_q <= ren_on;
			devclr_q <= devclr_d;
			rx_valid_q <= rx_valid_d;
			rx_data_q <= rx_data_d;
			rx_end_q <= rx_end_d;
		end
	end

	// interface clear aborts both engines; device clear returns to idle
	assign hs.abort = ifc_on | devclr_q;
	assign hs.acc_en = atn_on | listen_q;
	assign hs.src_en = talk_q & ~atn_on;

	// status summary and service request
	logic [7:0] stb_q, stb_d, sre_q, sre_d, stb_rd_q, stb_rd_d, report, events;
	logic rqs_q, rqs_d, poll_clr_q, poll_clr_d;

	always_comb begin
		events = 8'h00;
		events[STB_LOG] = log_complete_flag;
		events[STB_ESB] = esr_summary;
		events[STB_ERROR] = instrument_error;
		events[STB_ALARM] = alarm_active;
		events[STB_RANGE] = |{sensor_above_range, temperature_above_range,
			sensor_below_range, temperature_below_range};
		// fresh reading; bit one never set
		events[STB_FRESH] = fresh_reading_flag;
		// latched; poll clears, a new event in that cycle still wins
		stb_d = (poll_clr_q ? STB_RESET : stb_q) | events;
		// mask written by the enable command
		sre_d = sre_wr ? sre_wdata : sre_q;
		// enabled bit requests service; only with mask bit six
		rqs_d = sre_q[STB_RQS] & |(stb_q & sre_q & ~(8'h01 << STB_RQS));
		// bit six reflects the request in progress
		report = stb_q;
		report[STB_RQS] = rqs_q;
		stb_rd_d = stb_query ? report : stb_rd_q;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stb_q <= STB_RESET;
			sre_q <= SRE_RESET;
			stb_rd_q <= STB_RESET;
			rqs_q <= 1'b0;
		end else begin
			stb_q <= stb_d;
			sre_q <= sre_d;
			stb_rd_q <= stb_rd_d;
			rqs_q <= rqs_d;
		end
	end

	// talker sequencer: user bytes, terminator bytes and the poll answer
	typedef enum logic [2:0] {TX_IDLE, TX_BYTE, TX_TERM1, TX_TERM2, TX_POLL, TX_POLLED} ibss_tx_t;
	ibss_tx_t tx_st_q, tx_st_d;
	logic tx_req_q, tx_req_d, tx_eoi_q, tx_eoi_d, tx_ready_q, tx_ready_d, last_q, last_d;
	logic [7:0] tx_byte_q, tx_byte_d;

	assign hs.tx_req = tx_req_q;
	assign hs.tx_byte = tx_byte_q;
	assign hs.tx_eoi = tx_eoi_q;

	always_comb begin
		tx_st_d = tx_st_q;
		tx_req_d = 1'b0;
		tx_byte_d = tx_byte_q;
		tx_eoi_d = tx_eoi_q;
		tx_ready_d = 1'b0;
		last_d = last_q;
		poll_clr_d = 1'b0;
		case (tx_st_q)
			TX_IDLE: begin
				if (tx_ready_q && tx_valid) begin
					// end-or-identify marks the last byte itself
					tx_byte_d = tx_data;
					tx_eoi_d = tx_last && (term_q == TERM_EOI);
					last_d = tx_last;
					tx_req_d = 1'b1;
					tx_st_d = TX_BYTE;
				end else if (hs.src_en && spe_q) begin
					// poll answer is the status byte
					tx_byte_d = report;
					tx_eoi_d = 1'b0;
					tx_req_d = 1'b1;
					tx_st_d = TX_POLL;
				end else begin
					tx_ready_d = hs.src_en & ~spe_q;
				end
			end
			TX_BYTE: begin
				if (hs.tx_done) begin
					tx_st_d = TX_IDLE;
					if (last_q && term_q != TERM_EOI) begin
						tx_byte_d = (term_q == TERM_CRLF) ? CHAR_CR : CHAR_LF;
						tx_eoi_d = 1'b0;
						tx_req_d = 1'b1;
						tx_st_d = TX_TERM1;
					end
				end
			end
			TX_TERM1: begin
				if (hs.tx_done) begin
					tx_st_d = TX_IDLE;
					// second character for the paired forms
					if (term_q == TERM_CRLF || term_q == TERM_LFCR) begin
						tx_byte_d = (term_q == TERM_CRLF) ? CHAR_LF : CHAR_CR;
						tx_req_d = 1'b1;
						tx_st_d = TX_TERM2;
					end
				end
			end
			TX_TERM2: begin
				if (hs.tx_done) begin
					tx_st_d = TX_IDLE;
				end
			end
			TX_POLL: begin
				// the accepted poll byte clears the latch
				if (hs.tx_done) begin
					poll_clr_d = 1'b1;
					tx_st_d = TX_POLLED;
				end
			end
			TX_POLLED: begin
				// one answer per poll, until the controller takes attention back
				if (atn_on || !spe_q) begin
					tx_st_d = TX_IDLE;
				end
			end
			default: tx_st_d = TX_IDLE;
		endcase
		// a byte cut off by attention or clear is dropped, not resent
		if (hs.abort || (!hs.src_en && tx_st_q != TX_POLLED)) begin
			tx_st_d = TX_IDLE;
			tx_req_d = 1'b0;
			tx_ready_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_st_q <= TX_IDLE;
			tx_req_q <= 1'b0;
			tx_byte_q <= 8'h00;
			tx_eoi_q <= 1'b0;
			tx_ready_q <= 1'b0;
			last_q <= 1'b0;
			poll_clr_q <= 1'b0;
		end else begin
			tx_st_q <= tx_st_d;
			tx_req_q <= tx_req_d;
			tx_byte_q <= tx_byte_d;
			tx_eoi_q <= tx_eoi_d;
			tx_ready_q <= tx_ready_d;
			last_q <= last_d;
			poll_clr_q <= poll_clr_d;
		end
	end

	assign srq_n_oe = rqs_q;
	assign srq_active = rqs_q;
	assign stb_rdata = stb_rd_q;
	assign sre_rdata = sre_q;
	assign tx_ready = tx_ready_q;
	assign rx_valid = rx_valid_q;
	assign rx_data = rx_data_q;
	assign rx_end = rx_end_q;
	assign remote_mode = remote_q;
	assign local_lockout = lockout_q;
	assign device_clear = devclr_q;
	assign listen_active = listen_q;
	assign talk_active = talk_q;

endmodule : ibss_device

/* sim/ibss_chk_sva.sv */
// concurrent checks on the bus port and status ports of the device
`timescale 1ns/1ps
module ibss_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic srq_n_oe,
	input wire logic dav_n_oe,
	input wire logic sre_wr,
	input wire logic [7:0] sre_wdata,
	input wire logic [7:0] sre_rdata,
	input wire logic stb_query,
	input wire logic [7:0] stb_rdata,
	input wire logic fresh_reading_flag,
	input wire logic ren_n_in,
	input wire logic ifc_n_in,
	input wire logic atn_n_in,
	input wire logic ndac_n_in,
	input wire logic remote_mode,
	input wire logic listen_active,
	input wire logic talk_active
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_mask_write: assert property (sre_wr |=> sre_rdata == $past(sre_wdata))
		else $error("mask readback differs from write");
	a_fresh_latch: assert property (fresh_reading_flag ##3 stb_query |-> ##[1:2] stb_rdata[0])
		else $error("fresh reading bit not reported");
	a_srq_gate: assert property (!sre_rdata[6] && !$past(sre_rdata[6]) |-> !srq_n_oe)
		else $error("request asserted with request enable clear");
	a_srq_raise: assert property (fresh_reading_flag && sre_rdata[0] && sre_rdata[6] && !sre_wr
		|-> ##[1:3] srq_n_oe)
		else $error("enabled status bit did not raise request");
	a_remote_enter: assert property ($fell(ren_n_in) |-> ##[1:3] remote_mode)
		else $error("remote enable did not enter remote");
	a_ifc_abort: assert property (!ifc_n_in [*3] |-> !listen_active && !talk_active)
		else $error("interface clear left device addressed");
	a_role_excl: assert property (!(listen_active && talk_active))
		else $error("talker and listener at once");
	a_atn_quiet: assert property (!atn_n_in [*4] |-> !dav_n_oe)
		else $error("device sources data under attention");
	a_dav_hold: assert property (dav_n_oe && !ndac_n_in && atn_n_in && ifc_n_in |=> dav_n_oe)
		else $error("data valid released before acceptance");
	c_poll_byte: cover property (dav_n_oe);
	c_request: cover property (srq_n_oe);
	c_remote: cover property (remote_mode);
endmodule : ibss_chk

bind ibss_device ibss_chk i_chk (.clk(clk), .reset(reset), .srq_n_oe(srq_n_oe), .dav_n_oe(dav_n_oe),
	.sre_wr(sre_wr), .sre_wdata(sre_wdata), .sre_rdata(sre_rdata), .stb_query(stb_query),
	.stb_rdata(stb_rdata), .fresh_reading_flag(fresh_reading_flag), .ren_n_in(ren_n_in),
	.ifc_n_in(ifc_n_in), .atn_n_in(atn_n_in), .ndac_n_in(ndac_n_in), .remote_mode(remote_mode),
	.listen_active(listen_active), .talk_active(talk_active));

/* sim/ibss_ctl_model.sv */
// behavioural bus controller: sends commands and reads poll bytes
`timescale 1ns/1ps
module ibss_ctl_model (
	input wire logic clk,
	input wire logic [7:0] dio_n,
	input wire logic dav_n,
	input wire logic nrfd_n,
	input wire logic ndac_n,
	output logic [7:0] dio_oe,
	output logic dav_oe,
	output logic nrfd_oe,
	output logic ndac_oe,
	output logic atn_n,
	output logic ren_n,
	output logic ifc_n
);
	int stalls = 0;
	initial begin
		{dio_oe, dav_oe, nrfd_oe, ndac_oe} = 11'h000;
		{atn_n, ren_n, ifc_n} = 3'h7;
	end
	task automatic send_byte(input logic [7:0] b);
		int i;
		atn_n = 1'b0;
		dio_oe = b;
		for (i = 0; i < 400 && nrfd_n !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		dav_oe = 1'b1;
		for (i = 0; i < 400 && ndac_n !== 1'b1; i++) @(negedge clk);
		stalls += int'(i == 400);
		dav_oe = 1'b0;
		@(negedge clk);
		dio_oe = 8'h00;
		@(negedge clk);
	endtask : send_byte
	// talker or poll byte read with attention released
	task automatic read_byte(output logic [7:0] b);
		int i;
		atn_n = 1'b1;
		ndac_oe = 1'b1;
		for (i = 0; i < 600 && dav_n !== 1'b0; i++) @(negedge clk);
		stalls += int'(i == 600);
		b = ~dio_n;
		nrfd_oe = 1'b1;
		ndac_oe = 1'b0;
		for (i = 0; i < 400 && dav_n !== 1'b1; i++) @(negedge clk);
		nrfd_oe = 1'b0;
		@(negedge clk);
	endtask : read_byte
endmodule : ibss_ctl_model

/* sim/tb.sv */
// self-checking bench for the instrument bus status and service request block
`timescale 1ns/1ps
module tb;
	import ibss_pkg::*;
	localparam logic [4:0] MY_ADDR = 5'h05;
	localparam logic [7:0] EXP_BIT [9] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h04, 8'h04, 8'h01};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [8:0] ev = 9'h000;
	logic [4:0] addr_strap = MY_ADDR;
	ibss_term_t term_strap = TERM_CRLF;
	logic talk_only_strap = 1'b0;
	logic sre_wr = 1'b0;
	logic stb_query = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic [7:0] sre_wdata = 8'h00;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] stb_rdata, sre_rdata, d_dio_oe, c_dio_oe, v, exp_stb;
	logic [7:0] dclr_cnt = 8'h00;
	logic d_dav_oe, d_nrfd_oe, d_ndac_oe, d_eoi_oe, c_dav_oe, c_nrfd_oe, c_ndac_oe, atn_n, ren_n, ifc_n;
	logic srq_n_oe, remote_mode, local_lockout, device_clear, listen_active, talk_active;
	int err_count = 0;
	int n_checks = 0;
	wire [7:0] dio_w = ~(d_dio_oe | c_dio_oe);
	wire dav_w = ~(d_dav_oe | c_dav_oe);
	wire nrfd_w = ~(d_nrfd_oe | c_nrfd_oe);
	wire ndac_w = ~(d_ndac_oe | c_ndac_oe);

	always #2 clk = ~clk;
	always @(posedge clk) if (device_clear === 1'b1) dclr_cnt <= dclr_cnt + 8'h01;

	ibss_device #(.NUM_INPUTS(8)) i_dut (.clk(clk), .reset(reset), .dio_n_in(dio_w), .dio_n_out(),
		.dio_n_oe(d_dio_oe), .dav_n_in(dav_w), .dav_n_out(), .dav_n_oe(d_dav_oe), .nrfd_n_in(nrfd_w),
		.nrfd_n_out(), .nrfd_n_oe(d_nrfd_oe), .ndac_n_in(ndac_w), .ndac_n_out(), .ndac_n_oe(d_ndac_oe),
		.eoi_n_in(~d_eoi_oe), .eoi_n_out(), .eoi_n_oe(d_eoi_oe), .srq_n_out(), .srq_n_oe(srq_n_oe),
		.atn_n_in(atn_n), .ren_n_in(ren_n), .ifc_n_in(ifc_n), .addr_strap(addr_strap),
		.term_strap(term_strap), .talk_only_strap(talk_only_strap), .log_complete_flag(ev[0]),
		.esr_summary(ev[1]), .instrument_error(ev[2]), .alarm_active(ev[3]),
		.sensor_above_range({ev[4], 7'h00}), .temperature_above_range({7'h00, ev[5]}),
		.sensor_below_range({3'h0, ev[6], 4'h0}), .temperature_below_range({6'h00, ev[7], 1'b0}),
		.fresh_reading_flag(ev[8]), .sre_wr(sre_wr), .sre_wdata(sre_wdata), .stb_query(stb_query),
		.stb_rdata(stb_rdata), .sre_rdata(sre_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(), .rx_valid(), .rx_data(), .rx_end(), .remote_mode(remote_mode),
		.local_lockout(local_lockout), .device_clear(device_clear), .listen_active(listen_active),
		.talk_active(talk_active), .srq_active());

	ibss_ctl_model i_ctl (.clk(clk), .dio_n(dio_w), .dav_n(dav_w), .nrfd_n(nrfd_w), .ndac_n(ndac_w),
		.dio_oe(c_dio_oe), .dav_oe(c_dav_oe), .nrfd_oe(c_nrfd_oe), .ndac_oe(c_ndac_oe), .atn_n(atn_n),
		.ren_n(ren_n), .ifc_n(ifc_n));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	task automatic wr_mask(input logic [7:0] m);
		sre_wdata = m;
		sre_wr = 1'b1;
		step(1);
		sre_wr = 1'b0;
		step(1);
	endtask : wr_mask

	// query pulse, then the held answer is read once it has settled
	task automatic read_stb(output logic [7:0] s);
		stb_query = 1'b1;
		step(1);
		stb_query = 1'b0;
		step(2);
		s = stb_rdata;
	endtask : read_stb

	task automatic cmd(input logic [7:0] b);
		i_ctl.send_byte(b);
		step(3);
	endtask : cmd

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end

	initial begin
		step(4);
		reset = 1'b0;
		step(2);
		check(stb_rdata, STB_RESET);
		check(sre_rdata, SRE_RESET);
		check({srq_n_oe, remote_mode, listen_active, talk_active}, 8'h00);
		wr_mask(8'hBD);
		check(sre_rdata, 8'hBD);
		exp_stb = 8'h00;
		for (int i = 0; i < 9; i++) begin
			ev[i] = 1'b1;
			step(1);
			ev = 9'h000;
			step(2);
			exp_stb |= EXP_BIT[i];
			read_stb(v);
			check(v, exp_stb);
		end
		check(srq_n_oe, 1'b0);
		read_stb(v);
		check(v, exp_stb);
		wr_mask(8'hFF);
		step(3);
		check(srq_n_oe, 1'b1);
		$display("status latch test done");
		cmd({1'b0, GROUP_TALK, MY_ADDR});
		check({listen_active, talk_active}, 8'h01);
		cmd({1'b0, CMD_SPE});
		i_ctl.read_byte(v);
		check(v, exp_stb | 8'h40);
		cmd({1'b0, CMD_SPD});
		step(4);
		read_stb(v);
		check(v, 8'h00);
		check(srq_n_oe, 1'b0);
		ev[8] = 1'b1;
		step(1);
		ev = 9'h000;
		step(3);
		check(srq_n_oe, 1'b1);
		$display("serial poll test done");
		i_ctl.ren_n = 1'b0;
		step(3);
		check(remote_mode, 1'b1);
		cmd({1'b0, CMD_UNL});
		cmd({1'b0, CMD_GTL});
		check(remote_mode, 1'b1);
		cmd({1'b0, CMD_SDC});
		check(dclr_cnt, 8'h00);
		cmd({1'b0, CMD_LLO});
		check(local_lockout, 1'b1);
		cmd({1'b0, GROUP_LISTEN, MY_ADDR});
		check({listen_active, talk_active}, 8'h02);
		cmd({1'b0, CMD_GTL});
		check(remote_mode, 1'b0);
		cmd({1'b0, CMD_SDC});
		check(dclr_cnt, 8'h01);
		cmd({1'b0, CMD_DCL});
		check(dclr_cnt, 8'h02);
		$display("bus command test done");
		addr_strap = 5'h09;
		cmd({1'b0, GROUP_TALK, MY_ADDR});
		check({listen_active, talk_active}, 8'h01);
		tx_data = 8'h41;
		tx_last = 1'b1;
		tx_valid = 1'b1;
		i_ctl.read_byte(v);
		tx_valid = 1'b0;
		check(v, 8'h41);
		i_ctl.read_byte(v);
		check(v, CHAR_CR);
		i_ctl.read_byte(v);
		check(v, CHAR_LF);
		$display("talker test done");
		i_ctl.ifc_n = 1'b0;
		step(4);
		check({listen_active, talk_active}, 8'h00);
		i_ctl.ifc_n = 1'b1;
		check(8'(i_ctl.stalls), 8'h00);
		$display("interface clear test done");
		complete_run();
	end
endmodule : tb
